// >>> verilog/rsap_pkg.sv
package rsap_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int MEM_WORDS = 128;
    localparam int FIFO_DEPTH = 16;
    localparam int DIR_BIT = 7;
    localparam int WP_BIT = 6;
    localparam int KEY_HI = 7;
    localparam int KEY_LO = 4;
    localparam int DIODE_HI = 3;
    localparam int DIODE_LO = 2;
    localparam int RES_HI = 1;
    localparam int RES_LO = 0;
    localparam logic [6:0] ADDR_CONTROL = 7'h0f;
    localparam logic [6:0] ADDR_STATUS = 7'h10;
    localparam logic [6:0] ADDR_TRICKLE = 7'h11;
    localparam logic [6:0] RTC_BASE = 7'h00;
    localparam logic [6:0] RTC_TOP = 7'h1f;
    localparam logic [6:0] RAM_BASE = 7'h20;
    localparam logic [6:0] RAM_TOP = 7'h7f;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'h47;
    localparam logic [7:0] STATUS_VALUE = 8'h00;
    localparam logic [7:0] TRICKLE_RESET = 8'h00;
    localparam logic [3:0] KEY_ENABLE = 4'ha;
    localparam logic [1:0] DIODE_ONE = 2'h1;
    localparam logic [1:0] DIODE_TWO = 2'h2;
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;

    typedef enum logic [1:0] {
        RSAP_IDLE = 2'b00,
        RSAP_ADDR = 2'b01,
        RSAP_DATA = 2'b10
    } rsap_state_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } rsap_wr_t;

    typedef struct packed {
        logic enable;
        logic twoDiodes;
        logic [1:0] resistor;
    } rsap_chg_t;
endpackage

// >>> verilog/rsap_fifo.sv
`timescale 1ns/1ps
module rsap_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
    localparam logic [AW-1:0] PTR_ONE = AW'(1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] store_ff [0:DEPTH-1];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    wire push = inValid & inReady;
    wire pop = outValid & outReady;
    wire [AW-1:0] nxt_wrPtr = (wrPtr_ff == PTR_LAST) ? '0 : AW'(wrPtr_ff + PTR_ONE);
    wire [AW-1:0] nxt_rdPtr = (rdPtr_ff == PTR_LAST) ? '0 : AW'(rdPtr_ff + PTR_ONE);

    assign inReady = (count_ff != DEPTH_CNT);
    assign outValid = (count_ff != '0);
    assign outData = store_ff[rdPtr_ff];

    always_ff @(posedge core_clk) begin
        if (push) begin
            store_ff[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wrPtr_ff <= nxt_wrPtr;
            end
            if (pop) begin
                rdPtr_ff <= nxt_rdPtr;
            end
            if (push && !pop) begin
                count_ff <= (AW+1)'(count_ff + CNT_ONE);
            end else if (pop && !push) begin
                count_ff <= (AW+1)'(count_ff - CNT_ONE);
            end
        end
    end
endmodule

// >>> verilog/rsap_serial_port.sv
`timescale 1ns/1ps
// How it works
// - Strap high four-wire, low three-wire
// - Device is slave; master drives clocks
// - Chip select rise starts new transaction
// - Clock level at select sets idle
// - Strobe edge captures, opposite edge shifts
// - Deselected: ignore inputs, output hi-Z
// - Writes latch data, output stays hi-Z
// - Read output hi-Z until byte ready
// - Four-wire mode shifts MSB first
// - First byte is address, data follows
// - Address bit seven picks write/read
// - Single byte or burst until deselect
// - Pointer increments after each data byte
// - Clock area wraps to 00h/80h
// - RAM area wraps to 20h/A0h
// - Low primary supply blocks all writes
// - Charger enabled only by key 1010
// - Charger disabled after power-up
// - Resistor 01/10/11 chosen, 00 off
// - Three-wire: LSB first, rise in, fall out
// - Write-protect bit blocks all writes except to itself
module rsap_serial_port (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic interfaceSelectStrap,
    input wire logic chipSelect,
    input wire logic serialClk,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    input wire logic primaryBelowBattery,
    input wire logic commitHold,
    output logic fifoReady,
    output logic writeProtect,
    output rsap_pkg::rsap_chg_t charger
);
    localparam int WR_W = $bits(rsap_pkg::rsap_wr_t);

    // Pin synchronisers: strap, select, clock, data, supply compare
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    logic prevCs_ff;
    logic prevSclk_ff;
    rsap_pkg::rsap_state_t state_ff;
    logic spiMode_ff;
    logic idleHigh_ff;
    logic [2:0] bitCnt_ff;
    logic [7:0] shift_ff;
    logic [6:0] ptr_ff;
    logic write_ff;
    logic [7:0] tx_ff;
    logic txReady_ff;
    logic outBit_ff;
    logic outEn_ff;
    logic [7:0] control_ff;
    logic [7:0] trickle_ff;
    logic [7:0] mem_ff [0:rsap_pkg::MEM_WORDS-1];

    wire syncStrap = sync_ff[4];
    wire syncCs = sync_ff[3];
    wire syncSclk = sync_ff[2];
    wire syncSdi = sync_ff[1];
    wire syncLow = sync_ff[0];

    wire csRise = syncCs & ~prevCs_ff;
    wire sclkRise = syncSclk & ~prevSclk_ff;
    wire sclkFall = ~syncSclk & prevSclk_ff;
    wire inFrame = syncCs & ~csRise & (state_ff != rsap_pkg::RSAP_IDLE);
    // Four-wire: capture on return to idle; three-wire: capture on rise
    wire strobeRaw = spiMode_ff ? (idleHigh_ff ? sclkRise : sclkFall) : sclkRise;
    wire shiftRaw = spiMode_ff ? (idleHigh_ff ? sclkFall : sclkRise) : sclkFall;
    wire strobeEdge = inFrame & strobeRaw;
    wire shiftEdge = inFrame & shiftRaw;
    wire [7:0] nxt_shift = spiMode_ff ? {shift_ff[6:0], syncSdi} : {syncSdi, shift_ff[7:1]};
    wire byteDone = strobeEdge & (bitCnt_ff == rsap_pkg::BIT_LAST);
    wire addrDone = byteDone & (state_ff == rsap_pkg::RSAP_ADDR);
    wire dataDone = byteDone & (state_ff == rsap_pkg::RSAP_DATA);
    wire [2:0] nxt_bitCnt = 3'(bitCnt_ff + rsap_pkg::BIT_STEP);

    wire ptrAtRtcTop = (ptr_ff == rsap_pkg::RTC_TOP);
    wire ptrAtRamTop = (ptr_ff == rsap_pkg::RAM_TOP);
    wire [6:0] nxt_ptr = ptrAtRtcTop ? rsap_pkg::RTC_BASE :
        ptrAtRamTop ? rsap_pkg::RAM_BASE : 7'(ptr_ff + 7'h01);

    // Read source: start address after the address byte, else next location
    wire [6:0] rdAddr = addrDone ? nxt_shift[6:0] : nxt_ptr;
    wire rdControl = (rdAddr == rsap_pkg::ADDR_CONTROL);
    wire rdStatus = (rdAddr == rsap_pkg::ADDR_STATUS);
    wire rdTrickle = (rdAddr == rsap_pkg::ADDR_TRICKLE);
    wire [7:0] rdData = rdControl ? control_ff : rdStatus ? rsap_pkg::STATUS_VALUE :
        rdTrickle ? trickle_ff : mem_ff[rdAddr];

    // Write path through the FIFO
    rsap_pkg::rsap_wr_t pushEntry;
    rsap_pkg::rsap_wr_t popEntry;
    logic [WR_W-1:0] popBits;
    logic popValid;
    wire pushValid = dataDone & write_ff;
    wire popReady = ~commitHold;
    wire pop = popValid & popReady;
    wire wpSet = control_ff[rsap_pkg::WP_BIT];
    wire blocked = wpSet | syncLow;
    wire commit = pop & ~blocked;
    wire hitControl = (popEntry.addr == rsap_pkg::ADDR_CONTROL);
    wire hitStatus = (popEntry.addr == rsap_pkg::ADDR_STATUS);
    wire hitTrickle = (popEntry.addr == rsap_pkg::ADDR_TRICKLE);
    wire memWrite = commit & ~hitControl & ~hitStatus & ~hitTrickle;
    wire [7:0] controlWr = popEntry.data & rsap_pkg::CONTROL_WMASK;

    assign pushEntry.addr = ptr_ff;
    assign pushEntry.data = nxt_shift;
    assign popEntry = rsap_pkg::rsap_wr_t'(popBits);

    rsap_fifo #(
        .WIDTH(WR_W),
        .DEPTH(rsap_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .inValid(pushValid),
        .inReady(fifoReady),
        .inData(pushEntry),
        .outValid(popValid),
        .outReady(popReady),
        .outData(popBits)
    );

    // Charger decode
    wire [3:0] keyField = trickle_ff[rsap_pkg::KEY_HI:rsap_pkg::KEY_LO];
    wire [1:0] diodeField = trickle_ff[rsap_pkg::DIODE_HI:rsap_pkg::DIODE_LO];
    wire [1:0] resField = trickle_ff[rsap_pkg::RES_HI:rsap_pkg::RES_LO];
    wire diodeOk = (diodeField == rsap_pkg::DIODE_ONE) | (diodeField == rsap_pkg::DIODE_TWO);
    assign charger.enable = (keyField == rsap_pkg::KEY_ENABLE) & diodeOk & (resField != rsap_pkg::RES_NONE);
    assign charger.twoDiodes = (diodeField == rsap_pkg::DIODE_TWO);
    assign charger.resistor = resField;

    assign serialOut = outBit_ff;
    assign serialOutEn = outEn_ff;
    assign writeProtect = wpSet;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prevCs_ff <= 1'b0;
            prevSclk_ff <= 1'b0;
        end else begin
            meta_ff <= {interfaceSelectStrap, chipSelect, serialClk, serialIn, primaryBelowBattery};
            sync_ff <= meta_ff;
            prevCs_ff <= syncCs;
            prevSclk_ff <= syncSclk;
        end
    end

    // Frame sequencing; master owns clock and select
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= rsap_pkg::RSAP_IDLE;
            spiMode_ff <= 1'b0;
            idleHigh_ff <= 1'b0;
            bitCnt_ff <= rsap_pkg::BIT_FIRST;
            shift_ff <= '0;
            ptr_ff <= '0;
            write_ff <= 1'b0;
        end else if (!syncCs) begin
            state_ff <= rsap_pkg::RSAP_IDLE;
            bitCnt_ff <= rsap_pkg::BIT_FIRST;
        end else if (csRise) begin
            state_ff <= rsap_pkg::RSAP_ADDR;
            spiMode_ff <= syncStrap;
            idleHigh_ff <= syncSclk;
            bitCnt_ff <= rsap_pkg::BIT_FIRST;
        end else if (strobeEdge) begin
            shift_ff <= nxt_shift;
            bitCnt_ff <= nxt_bitCnt;
            if (addrDone) begin
                state_ff <= rsap_pkg::RSAP_DATA;
                ptr_ff <= nxt_shift[6:0];
                write_ff <= nxt_shift[rsap_pkg::DIR_BIT];
            end else if (dataDone) begin
                ptr_ff <= nxt_ptr;
            end
        end
    end

    // Output shifter; driven only once a read byte is loaded
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_ff <= '0;
            txReady_ff <= 1'b0;
            outBit_ff <= 1'b0;
            outEn_ff <= 1'b0;
        end else if (!syncCs) begin
            txReady_ff <= 1'b0;
            outEn_ff <= 1'b0;
        end else if ((addrDone && !nxt_shift[rsap_pkg::DIR_BIT]) || (dataDone && !write_ff)) begin
            tx_ff <= rdData;
            txReady_ff <= 1'b1;
        end else if (shiftEdge && txReady_ff && !write_ff) begin
            outBit_ff <= spiMode_ff ? tx_ff[7] : tx_ff[0];
            tx_ff <= spiMode_ff ? {tx_ff[6:0], 1'b0} : {1'b0, tx_ff[7:1]};
            outEn_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            control_ff <= rsap_pkg::CONTROL_RESET;
            trickle_ff <= rsap_pkg::TRICKLE_RESET;
        end else if (pop && hitControl && !syncLow) begin
            if (wpSet) begin
                control_ff[rsap_pkg::WP_BIT] <= popEntry.data[rsap_pkg::WP_BIT];
            end else begin
                control_ff <= controlWr;
            end
        end else if (commit && hitTrickle) begin
            trickle_ff <= popEntry.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (memWrite) begin
            mem_ff[popEntry.addr] <= popEntry.data;
        end
    end

    a_idle_hiz: assert property (@(posedge core_clk) disable iff (!rstn) !syncCs |=> !serialOutEn)
        else $error("output driven while deselected");
    a_write_hiz: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_ff == rsap_pkg::RSAP_DATA && write_ff) |-> !serialOutEn)
        else $error("output driven during write");
    a_addr_hiz: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_ff == rsap_pkg::RSAP_ADDR) |-> !serialOutEn && !txReady_ff)
        else $error("output driven before read byte ready");
    a_frame_start: assert property (@(posedge core_clk) disable iff (!rstn)
        csRise |=> state_ff == rsap_pkg::RSAP_ADDR && bitCnt_ff == rsap_pkg::BIT_FIRST)
        else $error("select rise did not start address phase");
    a_idle_level: assert property (@(posedge core_clk) disable iff (!rstn)
        csRise |=> idleHigh_ff == $past(syncSclk) && spiMode_ff == $past(syncStrap))
        else $error("idle level or mode not captured at select");
    a_dir_bit: assert property (@(posedge core_clk) disable iff (!rstn)
        addrDone |=> write_ff == $past(nxt_shift[7]) && ptr_ff == $past(nxt_shift[6:0]))
        else $error("direction or start address wrong");
    a_rtc_wrap: assert property (@(posedge core_clk) disable iff (!rstn)
        dataDone && ptrAtRtcTop |=> ptr_ff == rsap_pkg::RTC_BASE)
        else $error("clock area pointer did not wrap");
    a_ram_wrap: assert property (@(posedge core_clk) disable iff (!rstn)
        dataDone && ptrAtRamTop |=> ptr_ff == rsap_pkg::RAM_BASE)
        else $error("memory area pointer did not wrap");
    a_block_write: assert property (@(posedge core_clk) disable iff (!rstn)
        pop && blocked && hitTrickle |=> $stable(trickle_ff))
        else $error("write accepted while protected");
    a_charger_key: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(trickle_ff) && keyField != rsap_pkg::KEY_ENABLE |-> !charger.enable)
        else $error("charger enabled without key");
    a_bit_order: assert property (@(posedge core_clk) disable iff (!rstn)
        shiftEdge && txReady_ff && !write_ff && syncCs && !spiMode_ff |=> serialOut == $past(tx_ff[0]))
        else $error("three-wire bit order wrong");
    a_mode_latch: assert property (@(posedge core_clk) disable iff (!rstn)
        inFrame |=> $stable(spiMode_ff) && $stable(idleHigh_ff))
        else $error("mode or idle level changed inside a frame");
    a_sclk_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
        !syncCs |=> $stable(shift_ff) && $stable(ptr_ff))
        else $error("deselected port reacted to clock");
    a_partial_drop: assert property (@(posedge core_clk) disable iff (!rstn)
        !syncCs |=> state_ff == rsap_pkg::RSAP_IDLE && bitCnt_ff == rsap_pkg::BIT_FIRST)
        else $error("partial byte kept after deselect");
    a_bit_count: assert property (@(posedge core_clk) disable iff (!rstn)
        strobeEdge && !byteDone |=> bitCnt_ff == 3'($past(bitCnt_ff) + rsap_pkg::BIT_STEP))
        else $error("bit counter did not step on strobe");
    a_read_load: assert property (@(posedge core_clk) disable iff (!rstn)
        addrDone && !nxt_shift[rsap_pkg::DIR_BIT] |=> txReady_ff && tx_ff == $past(rdData))
        else $error("read byte not loaded after address");
    a_en_stays: assert property (@(posedge core_clk) disable iff (!rstn)
        serialOutEn && syncCs |=> serialOutEn)
        else $error("output released inside a read frame");
    a_no_drive_write: assert property (@(posedge core_clk) disable iff (!rstn)
        serialOutEn |-> !write_ff)
        else $error("output driven in a write frame");
    a_msb_first: assert property (@(posedge core_clk) disable iff (!rstn)
        shiftEdge && txReady_ff && !write_ff && syncCs && spiMode_ff |=> serialOut == $past(tx_ff[7]))
        else $error("four-wire bit order wrong");
    a_ptr_step: assert property (@(posedge core_clk) disable iff (!rstn)
        dataDone && !ptrAtRtcTop && !ptrAtRamTop |=> ptr_ff == 7'($past(ptr_ff) + 7'h01))
        else $error("pointer did not step after data byte");
    a_ptr_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        !dataDone && !addrDone |=> $stable(ptr_ff))
        else $error("pointer moved without a byte");
    a_mem_blocked: assert property (@(posedge core_clk) disable iff (!rstn)
        pop && blocked && !hitControl && !hitStatus && !hitTrickle |=>
            mem_ff[$past(popEntry.addr)] == $past(mem_ff[popEntry.addr]))
        else $error("memory written while blocked");
    a_ctrl_protect: assert property (@(posedge core_clk) disable iff (!rstn)
        pop && hitControl && wpSet |=> control_ff[2:0] == $past(control_ff[2:0]))
        else $error("control written while protected");
    a_low_block: assert property (@(posedge core_clk) disable iff (!rstn)
        pop && syncLow |=> $stable(control_ff) && $stable(trickle_ff))
        else $error("register written on low supply");
endmodule

// >>> verif/rsap_spi_master.sv
`timescale 1ns/1ps
module rsap_spi_master (
    input wire logic core_clk,
    input wire logic threeWire,
    input wire logic idleHigh,
    input wire logic dataIn,
    output logic cs,
    output logic sclk,
    output logic dataOut,
    output logic drive,
    output logic quiet
);
    logic [7:0] txBuf [20];
    logic [7:0] rxBuf [20];
    initial begin
        cs = 1'b0;
        sclk = 1'b0;
        dataOut = 1'b0;
        drive = 1'b0;
        quiet = 1'b0;
    end
    // Address byte then nbits data bits; a short count cuts a byte
    task automatic frame(input logic [7:0] addr, input int nbits);
        logic [7:0] sh;
        int k;
        @(negedge core_clk);
        sclk = threeWire ? 1'b0 : idleHigh;
        cs = 1'b1;
        drive = 1'b1;
        quiet = 1'b1;
        repeat (6) @(negedge core_clk);
        for (int i = 0; i < 8 + nbits; i++) begin
            if (i == 8) begin
                quiet = addr[7];
                drive = addr[7];
            end
            // Data moves two cycles clear of either clock edge
            repeat (2) @(negedge core_clk);
            sh = (i < 8) ? addr : txBuf[i / 8 - 1];
            k = threeWire ? i % 8 : 7 - i % 8;
            dataOut = drive ? sh[k] : ~dataOut;
            repeat (2) @(negedge core_clk);
            if (threeWire && i >= 8) begin
                rxBuf[i / 8 - 1][k] = dataIn;
            end
            sclk = ~sclk;
            repeat (4) @(negedge core_clk);
            if (!threeWire && i >= 8) begin
                rxBuf[i / 8 - 1][k] = dataIn;
            end
            sclk = ~sclk;
        end
        repeat (4) @(negedge core_clk);
        cs = 1'b0;
        drive = 1'b0;
        quiet = 1'b0;
        repeat (12) @(negedge core_clk);
    endtask
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic strap = 1'b1;
    logic idleHigh = 1'b0;
    logic belowBat = 1'b0;
    logic hold = 1'b0;
    logic serialOut, serialOutEn, fifoReady, writeProtect;
    logic mCs, mClk, mOut, mDrive, mQuiet;
    rsap_pkg::rsap_chg_t charger;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] tv [9] = '{8'ha5, 8'ha9, 8'ha7, 8'haa, 8'hb5, 8'ha4, 8'ha1, 8'had, 8'h55};
    // Shared line in three-wire mode, otherwise separate in and out
    wire logic lineIn = serialOutEn ? serialOut : ~serialOut;
    wire logic devIn = (!strap && serialOutEn) ? serialOut : mOut;

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    rsap_spi_master m_u (.core_clk(core_clk), .threeWire(~strap), .idleHigh(idleHigh), .dataIn(lineIn),
        .cs(mCs), .sclk(mClk), .dataOut(mOut), .drive(mDrive), .quiet(mQuiet));

    rsap_serial_port dut_u (.core_clk(core_clk), .rstn(rstn), .interfaceSelectStrap(strap), .chipSelect(mCs),
        .serialClk(mClk), .serialIn(devIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .primaryBelowBattery(belowBat), .commitHold(hold), .fifoReady(fifoReady),
        .writeProtect(writeProtect), .charger(charger));

    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        m_u.txBuf[0] = d;
        m_u.frame({1'b1, a}, 8);
    endtask

    task automatic rd(input logic [6:0] a, input int n);
        m_u.frame({1'b0, a}, 8 * n);
        check("serialOutEn idle", {7'h00, serialOutEn}, 8'h00);
    endtask

    task automatic checkChg(input logic [7:0] d);
        logic en;
        en = d[7:4] == rsap_pkg::KEY_ENABLE && d[1:0] != rsap_pkg::RES_NONE
            && (d[3:2] == rsap_pkg::DIODE_ONE || d[3:2] == rsap_pkg::DIODE_TWO);
        check("chargerEnable", {7'h00, charger.enable}, {7'h00, en});
        if (en) begin
            check("chargerSel", {5'h00, charger.twoDiodes, charger.resistor}, {5'h00, d[3], d[1:0]});
        end
    endtask

    // Output must stay released through address bytes and write frames
    always @(posedge core_clk) begin
        if (mQuiet) begin
            check("serialOutEn quiet", {7'h00, serialOutEn}, 8'h00);
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        repeat (8) @(negedge core_clk);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        check("chargerEnable", {7'h00, charger.enable}, 8'h00);
        check("fifoReady", {7'h00, fifoReady}, 8'h01);
        wr(7'h0f, 8'h00);
        check("writeProtect", {7'h00, writeProtect}, 8'h00);
        foreach (tv[i]) begin
            wr(rsap_pkg::ADDR_TRICKLE, tv[i]);
            checkChg(tv[i]);
            rd(rsap_pkg::ADDR_TRICKLE, 1);
            check("trickle", m_u.rxBuf[0], tv[i]);
        end
        idleHigh = 1'b1;
        wr(7'h22, 8'h96);
        rd(7'h22, 1);
        check("idle high", m_u.rxBuf[0], 8'h96);
        idleHigh = 1'b0;
        m_u.txBuf[0] = 8'h11;
        m_u.txBuf[1] = 8'h22;
        m_u.txBuf[2] = 8'h33;
        m_u.frame(8'hfe, 24);
        rd(7'h7e, 3);
        check("ram wrap0", m_u.rxBuf[0], 8'h11);
        check("ram wrap1", m_u.rxBuf[1], 8'h22);
        check("ram wrap2", m_u.rxBuf[2], 8'h33);
        m_u.txBuf[0] = 8'h44;
        m_u.txBuf[1] = 8'h59;
        m_u.frame(8'h9f, 16);
        rd(7'h1f, 2);
        check("rtc wrap0", m_u.rxBuf[0], 8'h44);
        check("rtc wrap1", m_u.rxBuf[1], 8'h59);
        wr(7'h0f, 8'h40);
        check("writeProtect", {7'h00, writeProtect}, 8'h01);
        wr(7'h20, 8'h55);
        rd(7'h20, 1);
        check("protected", m_u.rxBuf[0], 8'h33);
        wr(rsap_pkg::ADDR_TRICKLE, 8'ha5);
        rd(rsap_pkg::ADDR_TRICKLE, 1);
        check("trickle protected", m_u.rxBuf[0], 8'h55);
        wr(7'h0f, 8'h00);
        check("writeProtect", {7'h00, writeProtect}, 8'h00);
        belowBat = 1'b1;
        wr(7'h20, 8'h66);
        belowBat = 1'b0;
        rd(7'h20, 1);
        check("low supply", m_u.rxBuf[0], 8'h33);
        m_u.txBuf[0] = 8'h77;
        m_u.frame(8'ha0, 4);
        rd(7'h20, 1);
        check("partial byte", m_u.rxBuf[0], 8'h33);
        hold = 1'b1;
        for (int i = 0; i < 17; i++) begin
            m_u.txBuf[i] = 8'h80 + 8'(i);
        end
        m_u.frame(8'hc0, 136);
        check("fifoReady full", {7'h00, fifoReady}, 8'h00);
        hold = 1'b0;
        repeat (40) @(negedge core_clk);
        check("fifoReady drained", {7'h00, fifoReady}, 8'h01);
        rd(7'h40, 16);
        for (int i = 0; i < 16; i++) begin
            check("burst", m_u.rxBuf[i], 8'h80 + 8'(i));
        end
        strap = 1'b0;
        wr(7'h21, 8'h3c);
        rd(7'h21, 1);
        check("three-wire", m_u.rxBuf[0], 8'h3c);
        strap = 1'b1;
        rd(7'h21, 1);
        check("four-wire", m_u.rxBuf[0], 8'h3c);
        finish_test();
    end
endmodule
